// >>> verilog/dbgtr_trigger_status.sv
// The APB register port and the address map are this design's own decisions.
`default_nettype none
module dbgtr_trigger_status #(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 8
) (
    input  wire logic              core_clk,
    input  wire logic              reset,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // observed core bus
    input  wire logic              busValid,
    input  wire logic [ADDR_W-1:0] busAddr,
    input  wire logic [DATA_W-1:0] busData,
    input  wire logic              opExec,
    input  wire logic [ADDR_W-1:0] execAddr,
    input  wire logic              flowStore,
    // comparator values and security
    input  wire logic [ADDR_W-1:0] compareA,
    input  wire logic [ADDR_W-1:0] compareB,
    input  wire logic              secureState,
    // fifo and cpu side
    output logic                   fifoPush,
    output logic                   cpuBreakReq,
    output logic                   cpuBreakTag,
    output logic                   moduleEnable,
    output logic                   armedFlag
);

    // event-only modes run as begin traces
    function automatic logic isEventMode(input logic [3:0] mode);
        isEventMode = (mode == dbgtr_pkg::MODE_EVT_B) ||
                      (mode == dbgtr_pkg::MODE_A_EVT_B);
    endfunction

    // trigger decode per mode
    function automatic logic trigFire(
        input logic [3:0] mode,
        input logic       hA,
        input logic       hB,
        input logic       dB,
        input logic       inR,
        input logic       ev,
        input logic       seen
    );
        case (mode)
            dbgtr_pkg::MODE_A_ONLY:   trigFire = hA;
            dbgtr_pkg::MODE_A_OR_B:   trigFire = hA | hB;
            dbgtr_pkg::MODE_A_THEN_B: trigFire = hB & seen;
            dbgtr_pkg::MODE_A_AND_DB: trigFire = hA & dB;
            dbgtr_pkg::MODE_A_NOT_DB: trigFire = hA & ~dB;
            dbgtr_pkg::MODE_INSIDE:   trigFire = ev & inR;
            dbgtr_pkg::MODE_OUTSIDE:  trigFire = ev & ~inR;
            default:                  trigFire = 1'b0;
        endcase
    endfunction

    logic [7:0]             ctrlReg;
    logic [7:0]             trigReg;
    logic                   afReg;
    logic                   bfReg;
    logic                   seenAReg;
    logic [3:0]             cntReg;
    logic [3:0]             cntNext;
    logic [31:0]            prdataReg;
    logic                   slvErrReg;
    logic                   pushReg;
    logic                   breakReg;
    dbgtr_pkg::dbgtr_run_t  runState;
    dbgtr_pkg::dbgtr_run_t  runNext;

    // apb decode
    logic setupPhase;
    logic wrCycle;
    logic wrCtrl;
    logic wrTrig;
    logic mapped;
    assign setupPhase = psel & ~penable;
    assign wrCycle    = psel & penable & pwrite;
    assign wrCtrl     = wrCycle & (paddr == dbgtr_pkg::OFS_CONTROL);
    assign wrTrig     = wrCycle & (paddr == dbgtr_pkg::OFS_TRIGGER);
    assign mapped     = (paddr == dbgtr_pkg::OFS_CONTROL) ||
                        (paddr == dbgtr_pkg::OFS_TRIGGER) ||
                        (paddr == dbgtr_pkg::OFS_STATUS);

    // field views
    logic [3:0] trigMode;
    logic       typeSel;
    logic       beginSel;
    logic       evtMode;
    logic       beginTrace;
    logic       enBit;
    logic       break_request_enable;
    assign trigMode   = trigReg[dbgtr_pkg::TRG_MODE_HI -: 4];
    assign typeSel    = trigReg[dbgtr_pkg::TRG_TYPESEL];
    assign beginSel   = trigReg[dbgtr_pkg::TRG_BEGIN];
    assign evtMode    = isEventMode(trigMode);
    assign beginTrace = evtMode | beginSel;
    assign enBit      = ctrlReg[dbgtr_pkg::CTL_ENABLE];
    assign break_request_enable      = ctrlReg[dbgtr_pkg::CTL_BREAK_REQUEST_ENABLE];

    // qualified event: executed opcode or plain bus access
    logic              evValid;
    logic [ADDR_W-1:0] evAddr;
    assign evValid = typeSel ? opExec : busValid;
    assign evAddr  = typeSel ? execAddr : busAddr;

    // comparator hits: address on the qualified event, data B on the bus access
    logic hitA;
    logic hitB;
    logic dataB;
    logic inRange;
    assign hitA    = evValid & (evAddr == compareA);
    assign hitB    = evValid & (evAddr == compareB);
    assign dataB   = busValid & (busData == compareB[DATA_W-1:0]);
    assign inRange = (evAddr >= compareA) && (evAddr <= compareB);

    // control write handling
    logic ctrlEnWr;
    logic ctrlArmWr;
    logic startRun;
    logic manualStop;
    assign ctrlEnWr  = pwdata[dbgtr_pkg::CTL_ENABLE] &
                       (enBit | ~secureState);
    assign ctrlArmWr = pwdata[dbgtr_pkg::CTL_ARM] & ctrlEnWr;
    assign startRun  = wrCtrl & ctrlArmWr &
                       (runState == dbgtr_pkg::RS_IDLE);
    assign manualStop = wrCtrl & ~ctrlArmWr &
                        (runState != dbgtr_pkg::RS_IDLE);

    // trigger and storage qualification
    logic armedNow;
    logic trigHit;
    logic evtStore;
    logic storeNow;
    logic fullNow;
    logic endTrig;
    logic beginFull;
    assign armedNow = (runState != dbgtr_pkg::RS_IDLE);
    assign trigHit  = trigFire(trigMode, hitA, hitB, dataB, inRange,
                               evValid, seenAReg);
    assign evtStore = hitB & ((trigMode == dbgtr_pkg::MODE_EVT_B) |
                              seenAReg);

    // words written to the fifo this cycle
    always_comb begin
        storeNow = 1'b0;
        case (runState)
            dbgtr_pkg::RS_ARMED: storeNow = flowStore & ~beginTrace;
            dbgtr_pkg::RS_BEGIN: storeNow = evtMode ? evtStore : flowStore;
            default:             storeNow = 1'b0;
        endcase
    end

    assign fullNow   = storeNow & (cntReg == dbgtr_pkg::CNT_FULL - 
                                   dbgtr_pkg::CNT_ONE);
    assign beginFull = (runState == dbgtr_pkg::RS_BEGIN) & fullNow;
    assign endTrig   = (runState == dbgtr_pkg::RS_ARMED) & ~beginTrace &
                       trigHit;

    // run state sequencing
    always_comb begin
        runNext = runState;
        case (runState)
            dbgtr_pkg::RS_IDLE: begin
                if (startRun) begin
                    runNext = evtMode ? dbgtr_pkg::RS_BEGIN
                                      : dbgtr_pkg::RS_ARMED;
                end
            end
            dbgtr_pkg::RS_ARMED: begin
                if (manualStop || !enBit) begin
                    runNext = dbgtr_pkg::RS_IDLE;
                end else if (endTrig) begin
                    runNext = dbgtr_pkg::RS_IDLE;
                end else if (beginTrace && trigHit) begin
                    runNext = dbgtr_pkg::RS_BEGIN;
                end
            end
            dbgtr_pkg::RS_BEGIN: begin
                if (manualStop || !enBit || beginFull) begin
                    runNext = dbgtr_pkg::RS_IDLE;
                end
            end
            default: runNext = dbgtr_pkg::RS_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            runState <= dbgtr_pkg::RS_IDLE;
        end else begin
            runState <= runNext;
        end
    end

    // debug control register; arm bit follows the run state
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrlReg <= dbgtr_pkg::CTRL_RESET;
        end else begin
            if (wrCtrl) begin
                ctrlReg <= pwdata[7:0];
                ctrlReg[dbgtr_pkg::CTL_ENABLE] <= ctrlEnWr;
            end
            ctrlReg[dbgtr_pkg::CTL_ARM] <=
                (runNext != dbgtr_pkg::RS_IDLE);
        end
    end

    // trigger config register, locked while armed
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            trigReg <= dbgtr_pkg::TRIG_RESET;
        end else if (wrTrig && !armedNow) begin
            trigReg <= pwdata[7:0] & dbgtr_pkg::TRG_WMASK;
        end
    end

    // match flags: run start clears, match while armed sets
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            afReg <= 1'b0;
            bfReg <= 1'b0;
        end else if (startRun) begin
            afReg <= 1'b0;
            bfReg <= 1'b0;
        end else if (armedNow) begin
            if (hitA) begin
                afReg <= 1'b1;
            end
            if (hitB) begin
                bfReg <= 1'b1;
            end
        end
    end

    // sequence memory for A-then modes
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            seenAReg <= 1'b0;
        end else if (startRun) begin
            seenAReg <= 1'b0;
        end else if (armedNow && hitA) begin
            seenAReg <= 1'b1;
        end
    end

    // valid word count, saturating, never touched by fifo reads
    always_comb begin
        cntNext = cntReg;
        if (startRun) begin
            cntNext = dbgtr_pkg::CNT_ZERO;
        end else if (storeNow && cntReg != dbgtr_pkg::CNT_FULL) begin
            cntNext = cntReg + dbgtr_pkg::CNT_ONE;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cntReg <= dbgtr_pkg::CNT_ZERO;
        end else begin
            cntReg <= cntNext;
        end
    end

    // fifo push and cpu break request pulses
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pushReg  <= 1'b0;
            breakReg <= 1'b0;
        end else begin
            pushReg  <= storeNow;
            breakReg <= break_request_enable & (endTrig | beginFull);
        end
    end

    // apb read data captured in the setup phase
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            prdataReg <= 32'h0000_0000;
            slvErrReg <= 1'b0;
        end else if (setupPhase) begin
            slvErrReg <= ~mapped;
            prdataReg <= 32'h0000_0000;
            case (paddr)
                dbgtr_pkg::OFS_CONTROL: prdataReg[7:0] <= ctrlReg;
                dbgtr_pkg::OFS_TRIGGER: prdataReg[7:0] <= trigReg;
                dbgtr_pkg::OFS_STATUS: begin
                    prdataReg[dbgtr_pkg::STS_AF]   <= afReg;
                    prdataReg[dbgtr_pkg::STS_BF]   <= bfReg;
                    prdataReg[dbgtr_pkg::STS_ARMED_FLAG] <= armedNow & enBit;
                    prdataReg[dbgtr_pkg::STS_CNT_HI -: 4] <= cntReg;
                end
                default: prdataReg <= 32'h0000_0000;
            endcase
        end
    end

    // status writes fall through with no decode: read-only
    assign prdata       = prdataReg;
    assign pready       = 1'b1;
    assign pslverr      = slvErrReg & psel & penable;
    assign fifoPush     = pushReg;
    assign cpuBreakReq  = breakReg;
    assign cpuBreakTag  = ctrlReg[dbgtr_pkg::CTL_TAG];
    assign moduleEnable = enBit;
    assign armedFlag    = armedNow & enBit;

endmodule
`default_nettype wire

// >>> verilog/dbgtr_pkg.sv
// Contract
// - config readable any time, writable only disarmed; bits 5:4 read zero
// - type select one: match counts only when opcode at the address executes
// - type select zero: match counts on the bus access itself
// - begin select 0: circular store until trigger; 1: trigger starts storing
// - event-only modes ignore begin/end select and always run as begin trace
// - mode 0000 A alone, 0001 A or B, 0010 A then later B
// - mode 0011 store on each B; 0100 wait A then store each B
// - mode 0101 address A with data B; 0110 address A with data not B
// - mode 0111 address inside A..B inclusive; 1000 below A or above B
// - modes 1001 to 1111 never trigger
// - match A flag clears at run start, sets on A match while armed
// - match B flag clears at run start, sets on B match while armed
// - armed flag mirrors arm while enabled; set by arm write with enable
// - run ends, armed clears: FIFO full in begin or trigger in end trace
// - writing zero to arm or enable ends the run at once
// - valid count clears at run start, holds 0 to 8 valid words at end
// - valid count never decrements on FIFO reads
// - run status register read-only; writes change nothing
// - begin trace with breaks enabled: break request when FIFO becomes full
// - module enable cannot be set to one while the device is secure
`default_nettype none
package dbgtr_pkg;
    // register byte offsets on the APB bus
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_TRIGGER = 8'h04;
    localparam logic [7:0] OFS_STATUS  = 8'h08;
    // debug_control_reg fields
    localparam int CTL_ENABLE = 7;
    localparam int CTL_ARM    = 6;
    localparam int CTL_TAG    = 5;
    localparam int CTL_BREAK_REQUEST_ENABLE  = 4;
    // trigger_config fields
    localparam int TRG_TYPESEL = 7;
    localparam int TRG_BEGIN   = 6;
    localparam int TRG_MODE_HI = 3;
    // run_status fields
    localparam int STS_AF   = 7;
    localparam int STS_BF   = 6;
    localparam int STS_ARMED_FLAG = 5;
    localparam int STS_CNT_HI = 3;
    // writable mask of trigger_config (bits 4 and 5 hard zero)
    localparam logic [7:0] TRG_WMASK   = 8'hCF;
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] TRIG_RESET  = 8'h00;
    // fifo depth and count width
    localparam int FIFO_DEPTH = 8;
    localparam int CNT_W      = 4;
    localparam logic [3:0] CNT_FULL = 4'h8;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE  = 4'h1;
    // trigger modes
    localparam logic [3:0] MODE_A_ONLY    = 4'h0;
    localparam logic [3:0] MODE_A_OR_B    = 4'h1;
    localparam logic [3:0] MODE_A_THEN_B  = 4'h2;
    localparam logic [3:0] MODE_EVT_B     = 4'h3;
    localparam logic [3:0] MODE_A_EVT_B   = 4'h4;
    localparam logic [3:0] MODE_A_AND_DB  = 4'h5;
    localparam logic [3:0] MODE_A_NOT_DB  = 4'h6;
    localparam logic [3:0] MODE_INSIDE    = 4'h7;
    localparam logic [3:0] MODE_OUTSIDE   = 4'h8;
    // run state, one-hot
    typedef enum logic [2:0] {
        RS_IDLE  = 3'b001,
        RS_ARMED = 3'b010,
        RS_BEGIN = 3'b100
    } dbgtr_run_t;
endpackage
`default_nettype wire

// >>> tb/dbgtr_trigger_status_asserts.sv
`default_nettype none
module dbgtr_trigger_status_asserts (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        secureState,
    input wire logic        fifoPush,
    input wire logic        cpuBreakReq,
    input wire logic        moduleEnable,
    input wire logic        armedFlag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // completed control writes: arming from idle and stopping
    sequence s_ctl;
        psel && penable && pwrite && paddr == dbgtr_pkg::OFS_CONTROL;
    endsequence
    sequence s_arm;
        s_ctl ##0 (pwdata[7] && pwdata[6] && !armedFlag
            && (moduleEnable || !secureState));
    endsequence
    sequence s_stop;
        s_ctl ##0 !(pwdata[7] && pwdata[6]);
    endsequence
    sequence s_cfg_read;
        psel && penable && !pwrite && paddr == dbgtr_pkg::OFS_TRIGGER;
    endsequence
    // run control and trigger config properties
    property p_cfg_zero; s_cfg_read |-> prdata[5:4] == 2'b00; endproperty
    property p_secure;
        s_ctl ##0 (secureState && !moduleEnable) |=> !moduleEnable;
    endproperty
    property p_arm; s_arm |=> armedFlag; endproperty
    property p_armed_en; armedFlag |-> moduleEnable; endproperty
    property p_stop; s_stop |=> !armedFlag; endproperty
    property p_stop_quiet; s_stop |=> ##1 !fifoPush; endproperty
    property p_break_end; cpuBreakReq |-> $fell(armedFlag); endproperty
    property p_push_armed; fifoPush |-> $past(armedFlag); endproperty
    a_cfg_zero: assert property (p_cfg_zero)
        else $error("trigger config bits 5:4 read nonzero");
    a_secure: assert property (p_secure)
        else $error("module enabled while secure");
    a_arm: assert property (p_arm)
        else $error("arm write did not raise armed flag");
    a_armed_en: assert property (p_armed_en)
        else $error("armed flag without module enable");
    a_stop: assert property (p_stop)
        else $error("run not stopped by control write");
    a_stop_quiet: assert property (p_stop_quiet)
        else $error("fifo push after stopped run");
    a_break_end: assert property (p_break_end)
        else $error("break request without run end");
    a_push_armed: assert property (p_push_armed)
        else $error("fifo push while not armed");
endmodule
bind dbgtr_trigger_status dbgtr_trigger_status_asserts u_asserts (
    .core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .secureState, .fifoPush, .cpuBreakReq, .moduleEnable,
    .armedFlag
);
`default_nettype wire

// >>> tb/dbgtr_core_model.sv
`default_nettype none
module dbgtr_core_model (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic [1:0]  req,
    input  wire logic [15:0] reqAddr,
    input  wire logic [7:0]  reqData,
    output logic             busValid,
    output logic [15:0]      busAddr,
    output logic [7:0]       busData,
    output logic             opExec,
    output logic [15:0]      execAddr,
    output logic             flowStore
);
    timeunit 1ns;
    timeprecision 1ps;
    // one-cycle core events; idle lines flip so stale values never match
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            busValid  <= 1'b0;
            opExec    <= 1'b0;
            flowStore <= 1'b0;
            busAddr   <= 16'h0000;
            execAddr  <= 16'h0000;
            busData   <= 8'h00;
        end else begin
            busValid  <= req == 2'h1;
            opExec    <= req == 2'h2;
            flowStore <= req == 2'h3;
            busAddr   <= req == 2'h1 ? reqAddr : ~busAddr;
            execAddr  <= req == 2'h2 ? reqAddr : ~execAddr;
            busData   <= req == 2'h1 ? reqData : ~busData;
        end
    end
endmodule
`default_nettype wire

// >>> tb/debug_trigger_and_run_status_bench.sv
`default_nettype none
module debug_trigger_and_run_status_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, rv;
    logic        pready, pslverr, busValid, opExec, flowStore, lastErr, t;
    logic [15:0] busAddr, execAddr, x;
    logic [7:0]  busData, d, r;
    logic [15:0] compareA = 16'h1000;
    logic [15:0] compareB = 16'h3000;
    logic        secureState = 1'b0;
    logic        cpuBreakReq, brkTag, brkSeen = 1'b0;
    logic [1:0]  req = 2'h0;
    logic [15:0] reqAddr = 16'h0000;
    logic [7:0]  reqData = 8'h00;
    integer      seed = 32'h5F25B768;
    int          miscompares = 0, numChecks = 0, mi, j;
    always #4 core_clk = ~core_clk;
    // sticky record of break pulses within a run
    always @(posedge core_clk) if (cpuBreakReq === 1'b1) brkSeen <= 1'b1;
    dbgtr_trigger_status dut (.core_clk, .reset, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .busValid,
        .busAddr, .busData, .opExec, .execAddr, .flowStore, .compareA,
        .compareB, .secureState, .fifoPush(), .cpuBreakReq,
        .cpuBreakTag(brkTag), .moduleEnable(), .armedFlag());
    dbgtr_core_model coreModel (.core_clk, .reset, .req, .reqAddr,
        .reqData, .busValid, .busAddr, .busData, .opExec, .execAddr,
        .flowStore);
    task automatic finishTest();
        $display("checks %0d mismatches %0d", numChecks, miscompares);
        if (miscompares == 0 && numChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        numChecks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, wd);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one core event: 1 access, 2 execution, 3 flow word
    task automatic bus(input logic [1:0] k, input logic [15:0] a,
                       input logic [7:0] dv);
        @(posedge core_clk);
        req <= k;
        reqAddr <= a;
        reqData <= dv;
        @(posedge core_clk);
        req <= 2'h0;
        repeat (2) @(posedge core_clk);
    endtask
    task automatic st(input logic [7:0] e, input logic b);
        apb(1'b0, dbgtr_pkg::OFS_STATUS, 8'h00);
        chk("status", {24'h0, e}, rd & 32'h0000002F);
        chk("break", {31'h0, b}, {31'h0, brkSeen});
    endtask
    // stop, configure, arm with breaks, then expect a clean start
    task automatic run(input logic [7:0] cfg);
        apb(1'b1, dbgtr_pkg::OFS_CONTROL, 8'h80);
        apb(1'b1, dbgtr_pkg::OFS_TRIGGER, cfg);
        apb(1'b0, dbgtr_pkg::OFS_TRIGGER, 8'h00);
        chk("trigger", {24'h0, cfg & dbgtr_pkg::TRG_WMASK}, rd);
        brkSeen = 1'b0;
        apb(1'b1, dbgtr_pkg::OFS_CONTROL, 8'hD0);
        apb(1'b0, dbgtr_pkg::OFS_STATUS, 8'h00);
        chk("start", 32'h00000020, rd);
    endtask
    // expected trigger of one access at x with data dv
    function automatic logic trig(input logic [3:0] m,
                                  input logic [15:0] a, input logic [7:0] dv);
        case (m)
            4'h0: return a == compareA;
            4'h1: return a == compareA || a == compareB;
            4'h2: return a == compareB;
            4'h5: return a == compareA && dv == compareB[7:0];
            4'h6: return a == compareA && dv != compareB[7:0];
            4'h7: return a >= compareA && a <= compareB;
            4'h8: return a < compareA || a > compareB;
            default: return 1'b0;
        endcase
    endfunction
    initial begin
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        apb(1'b0, dbgtr_pkg::OFS_CONTROL, 8'h00);
        chk("control", {24'h0, dbgtr_pkg::CTRL_RESET}, rd);
        apb(1'b0, 8'h0C, 8'h00);
        chk("slverr", 32'h1, {31'h0, lastErr});
        r = 8'($random(seed));
        apb(1'b1, dbgtr_pkg::OFS_TRIGGER, r);
        apb(1'b1, dbgtr_pkg::OFS_CONTROL, 8'hE0);
        apb(1'b1, dbgtr_pkg::OFS_TRIGGER, ~r);
        chk("tag", 32'h1, {31'h0, brkTag});
        apb(1'b0, dbgtr_pkg::OFS_TRIGGER, 8'h00);
        chk("locked", {24'h0, r & dbgtr_pkg::TRG_WMASK}, rd);
        apb(1'b1, dbgtr_pkg::OFS_STATUS, 8'hFF);
        st(8'h20, 1'b0);
        apb(1'b1, dbgtr_pkg::OFS_CONTROL, 8'h00);
        secureState <= 1'b1;
        apb(1'b1, dbgtr_pkg::OFS_CONTROL, 8'h80);
        apb(1'b0, dbgtr_pkg::OFS_CONTROL, 8'h00);
        chk("secure", 32'h0, rd);
        secureState <= 1'b0;
        $display("test registers done");
        for (mi = 0; mi < 64; mi++) begin
            j = mi % 4;
            rv = $random(seed);
            compareA <= {4'h1, rv[11:0]};
            compareB <= {4'h3, rv[23:12]};
            run({4'h0, mi[5:2]});
            x = j == 0 ? compareA : j == 1 ? compareB :
                j == 2 ? compareA - 16'h0001 : compareA + 16'h0100;
            d = rv[24] ? compareB[7:0] : ~compareB[7:0];
            if (mi[5:2] == 4'h2) bus(2'h1, compareA, 8'h00);
            bus(2'h1, x, d);
            t = trig(mi[5:2], x, d);
            st({2'b00, !t, 1'b0, 3'h0, mi[5:2] == 4'h3 && j == 1},
               t);
            if (mi[5:2] == 4'h1)
                chk("flags", {30'h0, j == 0, j == 1},
                    {30'h0, rd[7:6]});
        end
        $display("test modes done");
        run(8'h40);
        bus(2'h3, 16'h0000, 8'h00);
        bus(2'h1, compareA, 8'h00);
        repeat (7) bus(2'h3, 16'h0000, 8'h00);
        st(8'h27, 1'b0);
        bus(2'h3, 16'h0000, 8'h00);
        st(8'h08, 1'b1);
        // host keeps its own tally: the count stays at its end value
        st(8'h08, 1'b1);
        run(8'h00);
        repeat (3) bus(2'h3, 16'h0000, 8'h00);
        bus(2'h1, compareA, 8'h00);
        st(8'h03, 1'b1);
        run(8'h03);
        repeat (8) bus(2'h1, compareB, 8'h00);
        st(8'h08, 1'b1);
        run(8'h80);
        bus(2'h1, compareA, 8'h00);
        st(8'h20, 1'b0);
        bus(2'h2, compareA, 8'h00);
        st(8'h00, 1'b1);
        run(8'h00);
        apb(1'b1, dbgtr_pkg::OFS_CONTROL, 8'h90);
        st(8'h00, 1'b0);
        $display("test runs done");
        finishTest();
    end
    // watchdog well beyond the about 1660 cycles the tests take
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        finishTest();
    end
endmodule
`default_nettype wire
